/* inc/lcd_matrix_driver_ctrl_defines.svh */
// Purpose: Constants for the dot-matrix panel driver
// Assumes: Register bus is AXI4-Lite, 32-bit words
// Notes: Offsets are byte addresses
`ifndef LCD_MATRIX_DRIVER_CTRL_DEFINES_SVH
`define LCD_MATRIX_DRIVER_CTRL_DEFINES_SVH
`define DISPLAY_CONTROL_ADDR 12'h000
`define OPTION_STATUS_ADDR 12'h004
`define SCAN_STATUS_ADDR 12'h008
`define DISPLAY_RAM_BASE 12'h600
`define RAM_BASE_WORD 10'h180
`define RAM_LOW_ADDR 11'h580
`define DC_ENABLE_BIT 0
`define DC_BLANK_BIT 1
`define DC_CONTRAST_LSB 2
`define DC_RESET 8'h02
`define GEOM_32 2'h0
`define GEOM_48 2'h1
`define GEOM_64 2'h2
`define BASE_32 11'h7E0
`define STEP_32 11'h020
`define BASE_48 11'h7C0
`define STEP_48 11'h040
`define SLOW_CLK_HZ 32768
`define CLK_HZ 100000000
`define SLOW_DIV_CYCLES (`CLK_HZ / `SLOW_CLK_HZ)
`define ROW_TICKS 8'h08
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

/* inc/lcd_matrix_driver_pkg.sv */
// Purpose: Types for the dot-matrix panel driver
// Assumes: Nothing beyond the defines header
// Notes: Holds types only
package lcd_matrix_driver_pkg;
  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b00,
    SCAN_FETCH = 2'b01,
    SCAN_HOLD = 2'b10
  } scan_state_t;
endpackage

/* rtl/lcd_matrix_driver_ctrl.sv */
// Purpose: Dot-matrix panel driver with display RAM and control register
// Assumes: AXI4-Lite register bus; slow clock derived by divider
// Notes: Analog bias levels leave the block as codes only
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`include "lcd_matrix_driver_ctrl_defines.svh"
module lcd_matrix_driver_ctrl (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [1:0] panel_geometry_option_in,
  input wire logic [3:0] bias_ratio_option_in,
  input wire logic fast_osc_type_option_in,
  input wire logic slow_osc_type_option_in,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] com_out,
  output logic [31:0] shared_row_column_pin_out,
  output logic [63:0] seg_out,
  output logic com_active_out,
  output logic [2:0] contrast_out,
  output logic [3:0] bias_ratio_out,
  output logic fast_osc_crystal_out,
  output logic slow_osc_crystal_out,
  output logic driver_on_out
);
  // Display RAM covers 580H..7FFH, byte per word
  localparam int RAM_DEPTH = 640;

  typedef struct packed {
    logic aw_held;
    logic [11:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] dctl;
    logic [1:0] geom;
    logic [3:0] bias;
    logic fosc;
    logic sosc;
    lcd_matrix_driver_pkg::scan_state_t scan;
    logic [5:0] row;
    logic [3:0] grp;
    logic [7:0] hold;
    logic [95:0] seg_acc;
    logic [31:0] com;
    logic [31:0] shared;
    logic [63:0] seg;
    logic com_act;
  } ctl_state_t;

  ctl_state_t state_ff;
  ctl_state_t nxt_state;
  logic [7:0] ram_ff [RAM_DEPTH];
  logic ram_we;
  logic [9:0] ram_waddr;
  logic slow_tick;

  slow_tick_divider #(
    .DIV(`SLOW_DIV_CYCLES)
  ) u_slow_tick (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tick_out(slow_tick)
  );

  // Display byte address for a group and row under the current geometry
  function automatic logic [10:0] map_addr(
    input logic [1:0] geom,
    input logic [3:0] grp,
    input logic [5:0] row
  );
    logic [10:0] a;
    a = 11'h000;
    case (geom)
      `GEOM_32:
      begin
        a = `BASE_32 - 11'(grp) * `STEP_32 + 11'(row[4:0]);
      end
      `GEOM_48, `GEOM_64:
      begin
        a = `BASE_48 - 11'(grp) * `STEP_48 + 11'(row);
      end
      default:
      begin
        a = 11'h000;
      end
    endcase
    return a;
  endfunction

  function automatic logic [5:0] rows_of(input logic [1:0] geom);
    logic [5:0] n;
    case (geom)
      `GEOM_32: n = 6'h1F;
      `GEOM_48: n = 6'h2F;
      default: n = 6'h3F;
    endcase
    return n;
  endfunction

  function automatic logic [3:0] groups_of(input logic [1:0] geom);
    logic [3:0] n;
    case (geom)
      `GEOM_32: n = 4'hB;
      `GEOM_48: n = 4'h9;
      default: n = 4'h7;
    endcase
    return n;
  endfunction

  logic [10:0] fetch_addr;
  logic [9:0] fetch_idx;
  logic [7:0] fetch_byte;
  logic geom_ok;

  always_comb
  begin
    geom_ok = (state_ff.geom != 2'h3);
    fetch_addr = map_addr(state_ff.geom, state_ff.grp, state_ff.row);
    fetch_idx = 10'(fetch_addr - `RAM_LOW_ADDR);
    fetch_byte = ram_ff[fetch_idx];
  end

  always_comb
  begin
    logic wr_fire;
    logic [11:0] a;
    logic [95:0] segs;
    logic [63:0] rowsel;
    wr_fire = 1'b0;
    a = 12'h000;
    segs = 96'h0;
    rowsel = 64'h0;
    nxt_state = state_ff;
    ram_we = 1'b0;
    ram_waddr = 10'h000;
    // Options are latched every cycle from on-chip straps
    nxt_state.geom = panel_geometry_option_in;
    nxt_state.bias = bias_ratio_option_in;
    nxt_state.fosc = fast_osc_type_option_in;
    nxt_state.sosc = slow_osc_type_option_in;

    // Write channel: address and data in either order
    if (s_axi_awvalid && !state_ff.aw_held)
    begin
      nxt_state.aw_held = 1'b1;
      nxt_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_ff.w_held)
    begin
      nxt_state.w_held = 1'b1;
      nxt_state.w_data = s_axi_wdata[7:0];
      nxt_state.w_lane0 = s_axi_wstrb[0];
    end
    if (state_ff.aw_held && state_ff.w_held && !state_ff.bvalid)
    begin
      wr_fire = 1'b1;
      a = state_ff.aw_addr;
      nxt_state.aw_held = 1'b0;
      nxt_state.w_held = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp = `AXI_OKAY;
    end
    if (wr_fire)
    begin
      if (a >= `DISPLAY_RAM_BASE && a[1:0] == 2'b00)
      begin
        ram_we = state_ff.w_lane0;
        ram_waddr = a[11:2] - `RAM_BASE_WORD;
      end
      else if (a == `DISPLAY_CONTROL_ADDR)
      begin
        if (state_ff.w_lane0)
        begin
          nxt_state.dctl = {3'b000, state_ff.w_data[4:0]};
        end
      end
      else if (a != `OPTION_STATUS_ADDR && a != `SCAN_STATUS_ADDR)
      begin
        nxt_state.bresp = `AXI_SLVERR;
      end
    end
    if (state_ff.bvalid && s_axi_bready)
    begin
      nxt_state.bvalid = 1'b0;
    end

    // Read channel: answer one cycle after the address is taken
    if (s_axi_arvalid && !state_ff.rvalid)
    begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rresp = `AXI_OKAY;
      nxt_state.rdata = 32'h0;
      if (s_axi_araddr >= `DISPLAY_RAM_BASE)
      begin
        nxt_state.rdata = {24'h0,
                           ram_ff[s_axi_araddr[11:2] - `RAM_BASE_WORD]};
      end
      else if (s_axi_araddr == `DISPLAY_CONTROL_ADDR)
      begin
        nxt_state.rdata = {24'h0, state_ff.dctl};
      end
      else if (s_axi_araddr == `OPTION_STATUS_ADDR)
      begin
        nxt_state.rdata = {22'h0, state_ff.sosc, state_ff.fosc,
                           state_ff.bias, state_ff.geom};
      end
      else if (s_axi_araddr == `SCAN_STATUS_ADDR)
      begin
        nxt_state.rdata = {24'h0, 2'(state_ff.scan), state_ff.row};
      end
      else
      begin
        nxt_state.rresp = `AXI_SLVERR;
      end
    end
    else if (state_ff.rvalid && s_axi_rready)
    begin
      nxt_state.rvalid = 1'b0;
    end

    // Scan engine, paced by the slow clock tick
    case (state_ff.scan)
      lcd_matrix_driver_pkg::SCAN_IDLE:
      begin
        nxt_state.row = 6'h00;
        nxt_state.grp = 4'h0;
        if (state_ff.dctl[`DC_ENABLE_BIT] && geom_ok && slow_tick)
        begin
          nxt_state.scan = lcd_matrix_driver_pkg::SCAN_FETCH;
        end
      end
      lcd_matrix_driver_pkg::SCAN_FETCH:
      begin
        nxt_state.seg_acc[8*state_ff.grp +: 8] = fetch_byte;
        if (state_ff.grp >= groups_of(state_ff.geom))
        begin
          nxt_state.grp = 4'h0;
          nxt_state.hold = 8'h00;
          nxt_state.scan = lcd_matrix_driver_pkg::SCAN_HOLD;
        end
        else
        begin
          nxt_state.grp = state_ff.grp + 4'h1;
        end
      end
      lcd_matrix_driver_pkg::SCAN_HOLD:
      begin
        if (slow_tick)
        begin
          if (state_ff.hold == `ROW_TICKS - 8'h01)
          begin
            nxt_state.scan = lcd_matrix_driver_pkg::SCAN_FETCH;
            if (state_ff.row >= rows_of(state_ff.geom))
            begin
              nxt_state.row = 6'h00;
            end
            else
            begin
              nxt_state.row = state_ff.row + 6'h01;
            end
          end
          else
          begin
            nxt_state.hold = state_ff.hold + 8'h01;
          end
        end
      end
      default:
      begin
        nxt_state.scan = lcd_matrix_driver_pkg::SCAN_IDLE;
      end
    endcase
    if (!state_ff.dctl[`DC_ENABLE_BIT] || !geom_ok)
    begin
      nxt_state.scan = lcd_matrix_driver_pkg::SCAN_IDLE;
    end

    // Pin drive built from the latched row and segment bytes
    segs = state_ff.seg_acc;
    rowsel = 64'h1 << state_ff.row;
    // Commons rest while the next row's bytes are being fetched
    if (state_ff.dctl[`DC_BLANK_BIT] ||
        state_ff.scan != lcd_matrix_driver_pkg::SCAN_HOLD)
    begin
      rowsel = 64'h0;
    end
    nxt_state.com = rowsel[31:0];
    nxt_state.seg = segs[63:0];
    case (state_ff.geom)
      `GEOM_32:
      begin
        for (int p = 0; p < 32; p++)
        begin
          nxt_state.shared[p] = segs[95 - p];
        end
      end
      `GEOM_48:
      begin
        for (int p = 0; p < 16; p++)
        begin
          nxt_state.shared[p] = rowsel[32 + p];
          nxt_state.shared[16 + p] = segs[79 - p];
        end
      end
      `GEOM_64:
      begin
        nxt_state.shared = rowsel[63:32];
      end
      default:
      begin
        nxt_state.shared = 32'h0;
      end
    endcase
    nxt_state.com_act = state_ff.dctl[`DC_ENABLE_BIT] &&
                        !state_ff.dctl[`DC_BLANK_BIT];
    if (state_ff.scan == lcd_matrix_driver_pkg::SCAN_IDLE)
    begin
      nxt_state.com = 32'h0;
      nxt_state.shared = 32'h0;
      nxt_state.seg = 64'h0;
      nxt_state.com_act = 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_ff <= '0;
      state_ff.dctl <= `DC_RESET;
      state_ff.scan <= lcd_matrix_driver_pkg::SCAN_IDLE;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Display RAM holds no reset; contents are software's to load
  always_ff @(posedge clk_in)
  begin
    if (ram_we)
    begin
      ram_ff[ram_waddr] <= state_ff.w_data;
    end
  end

  assign s_axi_awready = !state_ff.aw_held;
  assign s_axi_wready = !state_ff.w_held;
  assign s_axi_bvalid = state_ff.bvalid;
  assign s_axi_bresp = state_ff.bresp;
  assign s_axi_arready = !state_ff.rvalid;
  assign s_axi_rvalid = state_ff.rvalid;
  assign s_axi_rdata = state_ff.rdata;
  assign s_axi_rresp = state_ff.rresp;
  assign com_out = state_ff.com;
  assign shared_row_column_pin_out = state_ff.shared;
  assign seg_out = state_ff.seg;
  assign com_active_out = state_ff.com_act;
  assign contrast_out = state_ff.dctl[`DC_CONTRAST_LSB +: 3];
  assign bias_ratio_out = state_ff.bias;
  assign fast_osc_crystal_out = state_ff.fosc;
  assign slow_osc_crystal_out = state_ff.sosc;
  assign driver_on_out = state_ff.dctl[`DC_ENABLE_BIT];
endmodule // lcd_matrix_driver_ctrl

/* rtl/slow_tick_divider.sv */
// Purpose: One-cycle enable at the slow refresh rate
// Assumes: Single clock domain
// Notes: Period is DIV cycles of clk_in
module slow_tick_divider #(
  parameter int DIV = 3051
) (
  input wire logic clk_in,
  input wire logic rst_in,
  output logic tick_out
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } div_state_t;
  div_state_t state_ff;
  div_state_t nxt_state;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.tick = 1'b0;
    if (state_ff.cnt == 16'(DIV - 1))
    begin
      nxt_state.cnt = 16'h0000;
      nxt_state.tick = 1'b1;
    end
    else
    begin
      nxt_state.cnt = state_ff.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign tick_out = state_ff.tick;
endmodule // slow_tick_divider

/* test/lcd_glass_panel.sv */
// Purpose: Glass panel as seen from the driver pins
// Assumes: A selected common is high on com or shared pins
// Notes: Columns beyond the geometry's count read 0
module lcd_glass_panel (
  input wire logic [1:0] geometry_in,
  input wire logic [31:0] com_in,
  input wire logic [31:0] shared_in,
  input wire logic [63:0] seg_in,
  output logic row_valid_out,
  output logic [5:0] row_out,
  output logic [95:0] column_out
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb
  begin
    row_valid_out = 1'h0;
    row_out = 6'h00;
    column_out = {32'h0, seg_in};
    for (int p = 0; p < 32; p++)
    begin
      if (com_in[p])
      begin
        row_valid_out = 1'h1;
        row_out = 6'(p);
      end
      if (geometry_in == 2'h0 || (geometry_in == 2'h1 && p >= 16))
        column_out[95 - p] = shared_in[p];
      else if (shared_in[p])
      begin
        row_valid_out = 1'h1;
        row_out = 6'(32 + p);
      end
    end
  end
endmodule // lcd_glass_panel

/* test/lcd_matrix_driver_ctrl_sva.sv */
// Purpose: Port checks for the panel driver
// Assumes: One clock, asynchronous active-high reset
// Notes: Bound to the top module below
module lcd_matrix_driver_ctrl_sva (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [31:0] com_out,
  input wire logic [31:0] shared_row_column_pin_out,
  input wire logic [63:0] seg_out,
  input wire logic com_active_out,
  input wire logic driver_on_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  sequence write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_com_onehot: assert property ($onehot0(com_out))
    else $error("several commons selected");
  chk_off_quiet: assert property (
    !driver_on_out [*3] |-> !com_active_out && com_out == 32'h0
      && seg_out == 64'h0 && shared_row_column_pin_out == 32'h0)
    else $error("pins driven while off");
  chk_blank_com: assert property (
    !com_active_out [*3] |-> com_out == 32'h0)
    else $error("common selected while inactive");
  chk_write_lat: assert property (write_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_read_lat: assert property (read_taken |=> s_axi_rvalid)
    else $error("read response late");
  chk_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule // lcd_matrix_driver_ctrl_sva

bind lcd_matrix_driver_ctrl lcd_matrix_driver_ctrl_sva chk_u (
  .clk_in, .rst_in, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .com_out,
  .shared_row_column_pin_out, .seg_out, .com_active_out, .driver_on_out);

/* test/lcd_matrix_driver_ctrl_tb.sv */
// Purpose: Self-checking bench for the panel driver
// Assumes: Control reads back in bits 7:0, bias and oscillator straps held steady
// Notes: Observes row 0 of each geometry
`include "lcd_matrix_driver_ctrl_defines.svh"
module lcd_matrix_driver_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] wd;
    logic [7:0] rd;
    logic [2:0] ctr;
  } row_t;
  row_t rows [3] = '{'{8'hE2, 8'h02, 3'h0}, '{8'h1E, 8'h1E, 3'h7},
    '{8'h0A, 8'h0A, 3'h2}};
  logic clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic [1:0] panel_geometry_option_in = 2'h0;
  logic [3:0] bias_ratio_option_in = 4'h5;
  logic fast_osc_type_option_in = 1'h1;
  logic slow_osc_type_option_in = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, com_active_out, driver_on_out, row_valid;
  logic fast_osc_crystal_out, slow_osc_crystal_out;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, com_out, shared_row_column_pin_out, data;
  logic [63:0] seg_out;
  logic [2:0] contrast_out;
  logic [3:0] bias_ratio_out;
  logic [5:0] row;
  logic [95:0] column, exp_col;
  int miscompares = 0;
  int checks = 0;
  int n;

  always #5 clk_in = ~clk_in;

  lcd_matrix_driver_ctrl dut_u (
    .clk_in, .rst_in, .panel_geometry_option_in, .bias_ratio_option_in,
    .fast_osc_type_option_in, .slow_osc_type_option_in, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .com_out, .shared_row_column_pin_out, .seg_out,
    .com_active_out, .contrast_out, .bias_ratio_out, .fast_osc_crystal_out,
    .slow_osc_crystal_out, .driver_on_out);
  lcd_glass_panel panel_u (
    .geometry_in(panel_geometry_option_in), .com_in(com_out),
    .shared_in(shared_row_column_pin_out), .seg_in(seg_out),
    .row_valid_out(row_valid), .row_out(row), .column_out(column));

  task automatic check(input string name, input logic [95:0] exp,
    input logic [95:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask

  task automatic conclude();
    if (miscompares == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic give_up();
    miscompares++;
    conclude();
  endtask

  task automatic await_row();
    for (n = 0; row_valid !== 1'h1 && n < 8000; n++)
      @(negedge clk_in);
    if (n >= 8000)
      give_up();
    repeat (2) @(negedge clk_in);
  endtask

  // One write or read; every handshake is judged at a rising edge
  task automatic xfer(input logic wr, input logic [11:0] a,
    input logic [7:0] d);
    logic done;
    done = 1'h0;
    @(posedge clk_in);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_arvalid <= !wr;
    s_axi_bready <= wr;
    s_axi_rready <= !wr;
    for (int k = 0; !done; k++)
    begin
      @(posedge clk_in);
      if (s_axi_awready === 1'h1)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1)
        s_axi_wvalid <= 1'h0;
      if (s_axi_arready === 1'h1)
        s_axi_arvalid <= 1'h0;
      if (wr ? s_axi_bvalid === 1'h1 : s_axi_rvalid === 1'h1)
      begin
        done = 1'h1;
        resp = wr ? s_axi_bresp : s_axi_rresp;
        data = s_axi_rdata;
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
      end
      if (k > 200)
        give_up();
    end
  endtask

  initial
  begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'h0;
    @(negedge clk_in);
    check("driver on", 96'h0, driver_on_out);
    xfer(1'h0, `DISPLAY_CONTROL_ADDR, 8'h00);
    check("control reset", 96'h02, data);
    xfer(1'h0, `OPTION_STATUS_ADDR, 8'h00);
    check("options", 96'h54, data);
    check("straps", 96'h16, {bias_ratio_out, fast_osc_crystal_out,
      slow_osc_crystal_out});
    for (int i = 0; i < 3; i++)
    begin
      xfer(1'h1, `DISPLAY_CONTROL_ADDR, rows[i].wd);
      xfer(1'h0, `DISPLAY_CONTROL_ADDR, 8'h00);
      check("control", rows[i].rd, data);
      check("contrast", rows[i].ctr, contrast_out);
    end
    // Row 0 byte of group g is 7E0H-20H*g, word 800H+4*(addr-600H)
    for (int g = 0; g < 12; g++)
    begin
      xfer(1'h1, 12'hF80 - 12'(g * 128), {g[3:0], ~g[3:0]});
      check("ram write", `AXI_OKAY, resp);
      xfer(1'h0, 12'hF80 - 12'(g * 128), 8'h00);
      check("ram byte", {g[3:0], ~g[3:0]}, data);
      exp_col[g * 8 +: 8] = {g[3:0], ~g[3:0]};
    end
    xfer(1'h1, 12'h00C, 8'h5A);
    check("unmapped write", `AXI_SLVERR, resp);
    xfer(1'h0, 12'h00C, 8'h00);
    check("unmapped read", `AXI_SLVERR, resp);
    xfer(1'h1, `DISPLAY_CONTROL_ADDR, 8'h01);
    await_row();
    check("columns", exp_col, column);
    check("commons active", 96'h1, com_active_out);
    repeat (100) @(negedge clk_in);
    check("row", 96'h0, row);
    xfer(1'h1, `DISPLAY_CONTROL_ADDR, 8'h03);
    repeat (3) @(negedge clk_in);
    check("blank commons", 96'h0, com_out);
    check("blank columns", exp_col, column);
    @(posedge clk_in);
    panel_geometry_option_in <= 2'h3;
    repeat (4) @(negedge clk_in);
    check("reserved pins", 96'h0, {shared_row_column_pin_out,
      seg_out});
    @(posedge clk_in);
    panel_geometry_option_in <= 2'h0;
    xfer(1'h1, `DISPLAY_CONTROL_ADDR, 8'h00);
    repeat (3) @(negedge clk_in);
    check("off pins", 96'h0, {shared_row_column_pin_out, seg_out});
    check("off commons", 96'h0, com_out);
    @(posedge clk_in);
    panel_geometry_option_in <= 2'h1;
    exp_col = '0;
    // Row 0 byte of group g is 7C0H-40H*g; groups 8 and 9 lie below 600H
    for (int g = 0; g < 10; g++)
    begin
      xfer(1'h1, 12'hF00 - 12'(g * 256), {~g[3:0], g[3:0]});
      exp_col[g * 8 +: 8] = {~g[3:0], g[3:0]};
    end
    xfer(1'h1, `DISPLAY_CONTROL_ADDR, 8'h01);
    await_row();
    check("columns 48", exp_col, column);
    check("shared commons", 96'h0, shared_row_column_pin_out[15:0]);
    xfer(1'h1, `DISPLAY_CONTROL_ADDR, 8'h00);
    @(posedge clk_in);
    panel_geometry_option_in <= 2'h2;
    exp_col[95:64] = '0;
    xfer(1'h1, `DISPLAY_CONTROL_ADDR, 8'h01);
    await_row();
    check("columns 64", exp_col, column);
    check("row 64", 96'h0, row);
    conclude();
  end
endmodule // lcd_matrix_driver_ctrl_tb
